//--- verilog/bucs_defines.svh
`ifndef BUCS_DEFINES_SVH
`define BUCS_DEFINES_SVH

// opcodes decoded by the branch unit
`define BUCS_OP_NOP         8'h00
`define BUCS_OP_LONG_JUMP        8'h02
`define BUCS_OP_LONG_CALL       8'h12
`define BUCS_OP_RET         8'h22
`define BUCS_OP_INTERRUPT_RETURN        8'h32
`define BUCS_OP_JZ          8'h60
`define BUCS_OP_JNZ         8'h70
`define BUCS_OP_IJMP        8'h73
`define BUCS_OP_SHORT_RELATIVE_JUMP        8'h80
`define BUCS_OP_COMPARE_AND_BRANCH_AI     8'hb4
`define BUCS_OP_COMPARE_AND_BRANCH_AD     8'hb5
`define BUCS_OP_COMPARE_AND_BRANCH_I0     8'hb6
`define BUCS_OP_COMPARE_AND_BRANCH_I1     8'hb7
`define BUCS_OP_DECREMENT_AND_BRANCH_D      8'hd5
`define BUCS_OP_XMOVE_0     8'he0
`define BUCS_OP_XMOVE_1     8'he2
`define BUCS_OP_XMOVE_2     8'he3
`define BUCS_OP_XMOVE_3     8'hf0
`define BUCS_OP_XMOVE_4     8'hf2
`define BUCS_OP_XMOVE_5     8'hf3

// opcode field patterns
`define BUCS_ABSOLUTE_BLOCK_JUMP_LOW       5'h01
`define BUCS_ABSOLUTE_BLOCK_CALL_LOW      5'h11
`define BUCS_DECREMENT_AND_BRANCH_R_HIGH    5'h1b
`define BUCS_COMPARE_AND_BRANCH_R_HIGH    5'h17

// field positions
`define BUCS_ABS_HI_MSB     7
`define BUCS_ABS_HI_LSB     5
`define BUCS_LOW5_MSB       4
`define BUCS_HIGH5_LSB      3
`define BUCS_BLOCK_MSB      15
`define BUCS_BLOCK_LSB      11
`define BUCS_SIGN_BIT       7

// reset values
`define BUCS_RESET_PC       16'h0000
`define BUCS_RESET_IR       8'h00

// instruction lengths and cycle counts
`define BUCS_LEN_1          2'h1
`define BUCS_LEN_2          2'h2
`define BUCS_LEN_3          2'h3
`define BUCS_LAST_CYC_1     1'h0
`define BUCS_LAST_CYC_2     1'h1

`endif

//--- verilog/bucs_pkg.sv
package bucs_pkg;

    typedef enum logic [2:0] {
        BUCS_S1,
        BUCS_S2,
        BUCS_S3,
        BUCS_S4,
        BUCS_S5,
        BUCS_S6
    } bucs_state_t;

    typedef enum logic [4:0] {
        BUCS_CL_OTHER,
        BUCS_CL_NOP,
        BUCS_CL_SHORT_RELATIVE_JUMP,
        BUCS_CL_LONG_JUMP,
        BUCS_CL_ABSOLUTE_BLOCK_JUMP,
        BUCS_CL_ABSOLUTE_BLOCK_CALL,
        BUCS_CL_IJMP,
        BUCS_CL_LONG_CALL,
        BUCS_CL_RET,
        BUCS_CL_INTERRUPT_RETURN,
        BUCS_CL_JZ,
        BUCS_CL_JNZ,
        BUCS_CL_DECREMENT_AND_BRANCH_R,
        BUCS_CL_DECREMENT_AND_BRANCH_D,
        BUCS_CL_COMPARE_AND_BRANCH_AI,
        BUCS_CL_COMPARE_AND_BRANCH_AD,
        BUCS_CL_COMPARE_AND_BRANCH_RI,
        BUCS_CL_XMOVE
    } bucs_class_t;

endpackage

//--- verilog/bucs_seq_if.sv
`timescale 1ns/10ps
interface bucs_seq_if;
    bucs_pkg::bucs_state_t state;
    logic                  phase;

    modport seq (output state, output phase);
    modport core (input state, input phase);
endinterface

//--- verilog/bucs_sequencer.sv
`timescale 1ns/10ps
module bucs_sequencer (
    // clock and reset
    input  wire logic  i_clk,
    input  wire logic  i_reset_n,
    input  wire logic  i_ce,
    // state and phase
    bucs_seq_if.seq    seq
);

    // RQ17: two phases per state
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            seq.phase <= 1'b1;
        end else if (i_ce) begin
            seq.phase <= ~seq.phase;
        end
    end

    // RQ16: six states per cycle
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            seq.state <= bucs_pkg::BUCS_S6;
        end else if (i_ce && seq.phase) begin
            case (seq.state)
                bucs_pkg::BUCS_S1: seq.state <= bucs_pkg::BUCS_S2;
                bucs_pkg::BUCS_S2: seq.state <= bucs_pkg::BUCS_S3;
                bucs_pkg::BUCS_S3: seq.state <= bucs_pkg::BUCS_S4;
                bucs_pkg::BUCS_S4: seq.state <= bucs_pkg::BUCS_S5;
                bucs_pkg::BUCS_S5: seq.state <= bucs_pkg::BUCS_S6;
                bucs_pkg::BUCS_S6: seq.state <= bucs_pkg::BUCS_S1;
                default:           seq.state <= bucs_pkg::BUCS_S1;
            endcase
        end
    end

endmodule

//--- verilog/bucs_branch_unit.sv
`timescale 1ns/10ps
`include "bucs_defines.svh"
// Summary of operation
// RQ1: taken relative branch adds sign-extended offset
// RQ2: relative base is next instruction address
// RQ3: short jump is opcode plus displacement
// RQ4: long jump loads full 16-bit target
// RQ5: absolute jump takes three opcode bits
// RQ6: absolute target replaces low 11 bits
// RQ7: indexed jump target is pointer plus accumulator
// RQ8: long call 16-bit, absolute call 2K block
// RQ9: return resumes after the calling instruction
// RQ10: interrupt return also signals service finished
// RQ11: conditional branches all use relative format
// RQ12: zero tests read accumulator directly
// RQ13: decrement operand, write back, branch nonzero
// RQ14: compare branches when operands differ
// RQ15: unsigned compare, carry set when less
// RQ16: six states of two periods each
// RQ17: each state has two phases
// RQ18: two fetches per cycle, extras discarded
// RQ19: opcode in S1, fetch S4, end S6
// RQ20: external move skips fetches in cycle two
// RQ21: calls push low first, returns pop reverse
// RQ22: no operation only advances program counter
module bucs_branch_unit (
    // clock, reset, enable
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic        i_ce,
    // program memory
    input  wire logic [7:0]  i_code_byte,
    output logic      [15:0] o_code_addr,
    output logic             o_code_rd,
    // datapath inputs
    input  wire logic [7:0]  i_acc,
    input  wire logic [15:0] i_data_pointer,
    input  wire logic [7:0]  i_sp,
    input  wire logic [7:0]  i_operand_byte,
    // decoded instruction
    output logic      [7:0]  o_opcode,
    output logic      [7:0]  o_operand_addr,
    // datapath write-back
    output logic             o_operand_we,
    output logic      [7:0]  o_operand_wdata,
    output logic             o_carry_we,
    output logic             o_carry,
    output logic             o_sp_we,
    output logic      [7:0]  o_sp,
    // internal stack
    input  wire logic [7:0]  i_stack_byte,
    output logic      [7:0]  o_stack_addr,
    output logic             o_stack_we,
    output logic             o_stack_re,
    output logic      [7:0]  o_stack_wdata,
    // interrupt controller
    output logic             o_int_done
);

    bucs_seq_if seq_bus ();

    bucs_sequencer u_seq (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_ce      (i_ce),
        .seq       (seq_bus.seq)
    );

    logic [15:0]              pc;
    logic [7:0]               b2, b3;
    logic [7:0]               pop_hi, pop_lo;
    logic [1:0]               byte_cnt;
    logic                     cyc_idx;
    bucs_pkg::bucs_class_t    cls;
    logic [1:0]               len;
    logic                     last_cyc;
    logic                     is_call, is_ret;
    logic                     at_end, exec;
    logic                     issue1, issue2;
    logic                     cap1, cap2, cap3;
    logic                     need, skip_fetch;
    logic [7:0]               rel;
    logic [15:0]              rel_target;
    logic [7:0]               dec_val;
    logic [7:0]               cmp_first, cmp_second;
    logic [15:0]              next_pc;

    function automatic bucs_pkg::bucs_class_t classify(input logic [7:0] op);
        bucs_pkg::bucs_class_t c;
        c = bucs_pkg::BUCS_CL_OTHER;
        // RQ5: absolute forms by low bits
        if (op[`BUCS_LOW5_MSB:0] == `BUCS_ABSOLUTE_BLOCK_JUMP_LOW) begin
            c = bucs_pkg::BUCS_CL_ABSOLUTE_BLOCK_JUMP;
        end else if (op[`BUCS_LOW5_MSB:0] == `BUCS_ABSOLUTE_BLOCK_CALL_LOW) begin
            c = bucs_pkg::BUCS_CL_ABSOLUTE_BLOCK_CALL;
        end else if (op[7:`BUCS_HIGH5_LSB] == `BUCS_DECREMENT_AND_BRANCH_R_HIGH) begin
            c = bucs_pkg::BUCS_CL_DECREMENT_AND_BRANCH_R;
        end else if (op[7:`BUCS_HIGH5_LSB] == `BUCS_COMPARE_AND_BRANCH_R_HIGH) begin
            c = bucs_pkg::BUCS_CL_COMPARE_AND_BRANCH_RI;
        end else begin
            case (op)
                `BUCS_OP_NOP:     c = bucs_pkg::BUCS_CL_NOP;
                `BUCS_OP_LONG_JUMP:    c = bucs_pkg::BUCS_CL_LONG_JUMP;
                `BUCS_OP_LONG_CALL:   c = bucs_pkg::BUCS_CL_LONG_CALL;
                `BUCS_OP_RET:     c = bucs_pkg::BUCS_CL_RET;
                `BUCS_OP_INTERRUPT_RETURN:    c = bucs_pkg::BUCS_CL_INTERRUPT_RETURN;
                `BUCS_OP_JZ:      c = bucs_pkg::BUCS_CL_JZ;
                `BUCS_OP_JNZ:     c = bucs_pkg::BUCS_CL_JNZ;
                `BUCS_OP_IJMP:    c = bucs_pkg::BUCS_CL_IJMP;
                `BUCS_OP_SHORT_RELATIVE_JUMP:    c = bucs_pkg::BUCS_CL_SHORT_RELATIVE_JUMP;
                `BUCS_OP_COMPARE_AND_BRANCH_AI: c = bucs_pkg::BUCS_CL_COMPARE_AND_BRANCH_AI;
                `BUCS_OP_COMPARE_AND_BRANCH_AD: c = bucs_pkg::BUCS_CL_COMPARE_AND_BRANCH_AD;
                `BUCS_OP_COMPARE_AND_BRANCH_I0, `BUCS_OP_COMPARE_AND_BRANCH_I1: c = bucs_pkg::BUCS_CL_COMPARE_AND_BRANCH_RI;
                `BUCS_OP_DECREMENT_AND_BRANCH_D:  c = bucs_pkg::BUCS_CL_DECREMENT_AND_BRANCH_D;
                `BUCS_OP_XMOVE_0, `BUCS_OP_XMOVE_1, `BUCS_OP_XMOVE_2,
                `BUCS_OP_XMOVE_3, `BUCS_OP_XMOVE_4, `BUCS_OP_XMOVE_5: c = bucs_pkg::BUCS_CL_XMOVE;
                default:          c = bucs_pkg::BUCS_CL_OTHER;
            endcase
        end
        return c;
    endfunction

    assign cls = classify(o_opcode);

    // instruction length and cycle count
    always_comb begin
        len      = `BUCS_LEN_1;
        last_cyc = `BUCS_LAST_CYC_2;
        case (cls)
            // RQ3: two-byte relative and absolute forms
            bucs_pkg::BUCS_CL_SHORT_RELATIVE_JUMP, bucs_pkg::BUCS_CL_ABSOLUTE_BLOCK_JUMP, bucs_pkg::BUCS_CL_ABSOLUTE_BLOCK_CALL,
            bucs_pkg::BUCS_CL_JZ, bucs_pkg::BUCS_CL_JNZ, bucs_pkg::BUCS_CL_DECREMENT_AND_BRANCH_R:
                len = `BUCS_LEN_2;
            // RQ4: three-byte forms
            bucs_pkg::BUCS_CL_LONG_JUMP, bucs_pkg::BUCS_CL_LONG_CALL, bucs_pkg::BUCS_CL_DECREMENT_AND_BRANCH_D,
            bucs_pkg::BUCS_CL_COMPARE_AND_BRANCH_AI, bucs_pkg::BUCS_CL_COMPARE_AND_BRANCH_AD, bucs_pkg::BUCS_CL_COMPARE_AND_BRANCH_RI:
                len = `BUCS_LEN_3;
            bucs_pkg::BUCS_CL_IJMP, bucs_pkg::BUCS_CL_RET,
            bucs_pkg::BUCS_CL_INTERRUPT_RETURN, bucs_pkg::BUCS_CL_XMOVE: len = `BUCS_LEN_1;
            // RQ22: single byte, single cycle
            default: last_cyc = `BUCS_LAST_CYC_1;
        endcase
    end

    assign is_call = (cls == bucs_pkg::BUCS_CL_LONG_CALL) || (cls == bucs_pkg::BUCS_CL_ABSOLUTE_BLOCK_CALL);
    assign is_ret  = (cls == bucs_pkg::BUCS_CL_RET) || (cls == bucs_pkg::BUCS_CL_INTERRUPT_RETURN);

    // phase points within the machine cycle
    assign at_end = (seq_bus.state == bucs_pkg::BUCS_S6) && seq_bus.phase;
    assign exec   = at_end && (cyc_idx == last_cyc);
    assign issue1 = at_end;
    assign issue2 = (seq_bus.state == bucs_pkg::BUCS_S3) && seq_bus.phase;
    assign cap1   = (seq_bus.state == bucs_pkg::BUCS_S1) && seq_bus.phase;
    assign cap2   = (seq_bus.state == bucs_pkg::BUCS_S4) && seq_bus.phase;
    assign cap3   = (seq_bus.state == bucs_pkg::BUCS_S2) && seq_bus.phase;
    assign need   = (byte_cnt < len);

    // RQ20: only the external move skips fetches
    assign skip_fetch = (cls == bucs_pkg::BUCS_CL_XMOVE) && (issue1 ? !exec : issue2 && cyc_idx);

    // RQ18: fetch strobe in S1 and S4
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_code_rd <= 1'b0;
        end else if (i_ce) begin
            o_code_rd <= (issue1 || issue2) && !skip_fetch;
        end
    end

    // cycle index within the instruction
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            cyc_idx <= 1'b0;
        end else if (i_ce && at_end) begin
            cyc_idx <= exec ? 1'b0 : 1'b1;
        end
    end

    // RQ19: opcode latched in S1, operands after
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_opcode <= `BUCS_RESET_IR;
            b2       <= 8'h00;
            b3       <= 8'h00;
            byte_cnt <= 2'h0;
        end else if (i_ce) begin
            if (exec) begin
                byte_cnt <= 2'h0;
            end else if (cap1 && !cyc_idx) begin
                o_opcode <= i_code_byte;
                byte_cnt <= `BUCS_LEN_1;
            // RQ18: unneeded bytes are dropped
            end else if ((cap1 || cap2) && need) begin
                if (byte_cnt == `BUCS_LEN_1) begin
                    b2 <= i_code_byte;
                end else begin
                    b3 <= i_code_byte;
                end
                byte_cnt <= byte_cnt + 2'h1;
            end
        end
    end

    assign o_operand_addr = b2;

    // RQ11: relative offset is the last byte
    assign rel = (len == `BUCS_LEN_3) ? b3 : b2;
    // RQ1: sign-extended two's complement add
    // RQ2: pc already points past the branch
    assign rel_target = pc + {{8{rel[`BUCS_SIGN_BIT]}}, rel};
    assign dec_val    = i_operand_byte - 8'h01;

    // RQ14: operand pairs per compare form
    always_comb begin
        cmp_first  = i_operand_byte;
        cmp_second = b2;
        case (cls)
            bucs_pkg::BUCS_CL_COMPARE_AND_BRANCH_AI: cmp_first = i_acc;
            bucs_pkg::BUCS_CL_COMPARE_AND_BRANCH_AD: begin
                cmp_first  = i_acc;
                cmp_second = i_operand_byte;
            end
            default: cmp_first = i_operand_byte;
        endcase
    end

    // branch target selection
    always_comb begin
        next_pc = pc;
        case (cls)
            bucs_pkg::BUCS_CL_SHORT_RELATIVE_JUMP: next_pc = rel_target;
            // RQ4: full 16-bit target
            // RQ8: long call reaches all space
            bucs_pkg::BUCS_CL_LONG_JUMP,
            bucs_pkg::BUCS_CL_LONG_CALL: next_pc = {b2, b3};
            // RQ6: keep upper 5 bits
            // RQ8: absolute call within block
            bucs_pkg::BUCS_CL_ABSOLUTE_BLOCK_JUMP,
            bucs_pkg::BUCS_CL_ABSOLUTE_BLOCK_CALL: begin
                next_pc = {pc[`BUCS_BLOCK_MSB:`BUCS_BLOCK_LSB],
                           o_opcode[`BUCS_ABS_HI_MSB:`BUCS_ABS_HI_LSB], b2};
            end
            // RQ7: pointer plus accumulator
            bucs_pkg::BUCS_CL_IJMP: next_pc = i_data_pointer + {8'h00, i_acc};
            // RQ9: resume after the call
            bucs_pkg::BUCS_CL_RET,
            bucs_pkg::BUCS_CL_INTERRUPT_RETURN: next_pc = {pop_hi, pop_lo};
            // RQ12: accumulator tested directly
            bucs_pkg::BUCS_CL_JZ: next_pc = (i_acc == 8'h00) ? rel_target : pc;
            bucs_pkg::BUCS_CL_JNZ: next_pc = (i_acc != 8'h00) ? rel_target : pc;
            // RQ13: branch when decrement nonzero
            bucs_pkg::BUCS_CL_DECREMENT_AND_BRANCH_R,
            bucs_pkg::BUCS_CL_DECREMENT_AND_BRANCH_D: next_pc = (dec_val != 8'h00) ? rel_target : pc;
            // RQ14: branch when operands differ
            bucs_pkg::BUCS_CL_COMPARE_AND_BRANCH_AI,
            bucs_pkg::BUCS_CL_COMPARE_AND_BRANCH_AD,
            bucs_pkg::BUCS_CL_COMPARE_AND_BRANCH_RI: begin
                next_pc = (cmp_first != cmp_second) ? rel_target : pc;
            end
            default: next_pc = pc;
        endcase
    end

    // program counter
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            pc <= `BUCS_RESET_PC;
        end else if (i_ce) begin
            if (exec) begin
                pc <= next_pc;
            end else if (cap1 && !cyc_idx) begin
                pc <= pc + 16'h0001;
            // RQ18: no increment for ignored bytes
            end else if ((cap1 || cap2) && need) begin
                pc <= pc + 16'h0001;
            end
        end
    end

    assign o_code_addr = pc;

    // RQ21: push low then high, pop reverse
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_stack_we    <= 1'b0;
            o_stack_re    <= 1'b0;
            o_stack_addr  <= 8'h00;
            o_stack_wdata <= 8'h00;
        end else if (i_ce) begin
            o_stack_we <= 1'b0;
            o_stack_re <= 1'b0;
            if (cyc_idx == last_cyc && (cap1 || cap3)) begin
                if (is_call) begin
                    o_stack_we    <= 1'b1;
                    o_stack_addr  <= cap1 ? i_sp + 8'h01 : i_sp + 8'h02;
                    o_stack_wdata <= cap1 ? pc[7:0] + {7'h00, need} : pc[15:8];
                end else if (is_ret) begin
                    o_stack_re   <= 1'b1;
                    o_stack_addr <= cap1 ? i_sp : i_sp - 8'h01;
                end
            end
        end
    end

    // popped return address bytes
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            pop_hi <= 8'h00;
            pop_lo <= 8'h00;
        end else if (i_ce && is_ret && cyc_idx == last_cyc) begin
            if (cap3) begin
                pop_hi <= i_stack_byte;
            end else if ((seq_bus.state == bucs_pkg::BUCS_S3) && seq_bus.phase) begin
                pop_lo <= i_stack_byte;
            end
        end
    end

    // RQ21: stack pointer moves by two
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_sp_we <= 1'b0;
            o_sp    <= 8'h00;
        end else if (i_ce) begin
            o_sp_we <= exec && (is_call || is_ret);
            if (exec && is_call) begin
                o_sp <= i_sp + 8'h02;
            end else if (exec && is_ret) begin
                o_sp <= i_sp - 8'h02;
            end
        end
    end

    // RQ13: decremented operand written back
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_operand_we    <= 1'b0;
            o_operand_wdata <= 8'h00;
        end else if (i_ce) begin
            o_operand_we <= exec && ((cls == bucs_pkg::BUCS_CL_DECREMENT_AND_BRANCH_R) ||
                                     (cls == bucs_pkg::BUCS_CL_DECREMENT_AND_BRANCH_D));
            if (exec) begin
                o_operand_wdata <= dec_val;
            end
        end
    end

    // RQ15: unsigned less-than sets carry
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_carry_we <= 1'b0;
            o_carry    <= 1'b0;
        end else if (i_ce) begin
            o_carry_we <= exec && ((cls == bucs_pkg::BUCS_CL_COMPARE_AND_BRANCH_AI) ||
                                   (cls == bucs_pkg::BUCS_CL_COMPARE_AND_BRANCH_AD) ||
                                   (cls == bucs_pkg::BUCS_CL_COMPARE_AND_BRANCH_RI));
            if (exec) begin
                o_carry <= (cmp_first < cmp_second);
            end
        end
    end

    // RQ10: end-of-service notice on interrupt return
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_int_done <= 1'b0;
        end else if (i_ce) begin
            o_int_done <= exec && (cls == bucs_pkg::BUCS_CL_INTERRUPT_RETURN);
        end
    end

endmodule

//--- testbench/bucs_branch_monitor.sv
`timescale 1ns/10ps
module bucs_branch_monitor (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    // datapath inputs
    input  wire logic [7:0]  i_acc,
    input  wire logic [7:0]  i_sp,
    input  wire logic [7:0]  i_operand_byte,
    // design outputs
    input  wire logic [15:0] o_code_addr,
    input  wire logic        o_code_rd,
    input  wire logic [7:0]  o_opcode,
    input  wire logic [7:0]  o_operand_addr,
    input  wire logic        o_operand_we,
    input  wire logic [7:0]  o_operand_wdata,
    input  wire logic        o_carry_we,
    input  wire logic        o_carry,
    input  wire logic        o_sp_we,
    input  wire logic [7:0]  o_sp,
    input  wire logic [7:0]  o_stack_addr,
    input  wire logic        o_stack_we,
    input  wire logic        o_stack_re,
    input  wire logic        o_int_done
);
    logic [7:0] gap;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    // clocks since last fetch
    always_ff @(posedge i_clk) begin
        if (!i_reset_n || o_code_rd)
            gap <= 8'h00;
        else if (gap != 8'hff)
            gap <= gap + 8'h01;
    end

    property p_fetch_gap;
        o_code_rd |=> !o_code_rd [*5];
    endproperty
    a_fetch_gap: assert property (p_fetch_gap) else $error("fetch strobes too close");
    property p_fetch_bound;
        gap <= 8'h11;
    endproperty
    a_fetch_bound: assert property (p_fetch_bound) else $error("fetch missing");
    property p_addr_hold;
        o_code_rd |=> $stable(o_code_addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("fetch address moved");
    property p_int_done;
        o_int_done |-> o_opcode == 8'h32 && o_sp_we;
    endproperty
    a_int_done: assert property (p_int_done) else $error("stray service done");
    property p_carry;
        o_carry_we |-> o_carry == ((o_opcode == 8'hb4) ? ($past(i_acc) < o_operand_addr) :
            (o_opcode == 8'hb5) ? ($past(i_acc) < $past(i_operand_byte)) :
            ($past(i_operand_byte) < o_operand_addr));
    endproperty
    a_carry: assert property (p_carry) else $error("compare carry wrong");
    property p_dec;
        o_operand_we |-> o_operand_wdata == $past(i_operand_byte) - 8'h01;
    endproperty
    a_dec: assert property (p_dec) else $error("decrement value wrong");
    property p_sp;
        o_sp_we |-> o_sp == ((o_opcode[5] && o_opcode[3:0] == 4'h2) ?
            $past(i_sp) - 8'h02 : $past(i_sp) + 8'h02);
    endproperty
    a_sp: assert property (p_sp) else $error("stack pointer wrong");
    property p_push;
        o_stack_we ##2 o_stack_we |-> o_stack_addr == $past(o_stack_addr, 2) + 8'h01;
    endproperty
    a_push: assert property (p_push) else $error("push order wrong");
    property p_pop;
        o_stack_re ##2 o_stack_re |-> o_stack_addr == $past(o_stack_addr, 2) - 8'h01;
    endproperty
    a_pop: assert property (p_pop) else $error("pop order wrong");
endmodule

bind bucs_branch_unit bucs_branch_monitor u_mon (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_acc(i_acc), .i_sp(i_sp),
    .i_operand_byte(i_operand_byte), .o_code_addr(o_code_addr), .o_code_rd(o_code_rd),
    .o_opcode(o_opcode), .o_operand_addr(o_operand_addr), .o_operand_we(o_operand_we),
    .o_operand_wdata(o_operand_wdata), .o_carry_we(o_carry_we), .o_carry(o_carry),
    .o_sp_we(o_sp_we), .o_sp(o_sp), .o_stack_addr(o_stack_addr), .o_stack_we(o_stack_we),
    .o_stack_re(o_stack_re), .o_int_done(o_int_done));

//--- testbench/bucs_code_mem.sv
`timescale 1ns/10ps
module bucs_code_mem (
    // clock
    input  wire logic        i_clk,
    // fetch port
    input  wire logic [15:0] i_addr,
    input  wire logic        i_rd,
    output logic      [7:0]  o_byte
);
    logic [7:0] mem [0:65535];
    logic [7:0] last;

    initial begin
        for (int a = 0; a < 65536; a++) mem[a] = 8'h00;
    end

    // byte valid one clock after strobe, then scrambled
    always @(posedge i_clk) begin
        if (i_rd) begin
            o_byte <= mem[i_addr];
            last <= mem[i_addr];
        end else begin
            o_byte <= ~last;
        end
    end
endmodule

//--- testbench/bucs_branch_unit_bench.sv
`timescale 1ns/10ps
module bucs_branch_unit_bench;
    typedef struct {
        logic [15:0] pc;
        logic [23:0] cd;
        int          cy;
        logic [7:0]  ac;
        logic [7:0]  ob;
        logic [7:0]  sp;
    } bucs_row_t;

    logic        i_clk, i_reset_n, i_ce;
    logic [7:0]  i_code_byte, i_acc, i_sp, i_operand_byte, i_stack_byte;
    logic [15:0] i_data_pointer, o_code_addr;
    logic [7:0]  o_opcode, o_operand_addr, o_operand_wdata, o_sp, o_stack_addr, o_stack_wdata;
    logic        o_code_rd, o_operand_we, o_carry_we, o_carry, o_sp_we;
    logic        o_stack_we, o_stack_re, o_int_done;
    logic [7:0]  stk [0:255];
    logic [7:0]  slast;
    bucs_row_t   rows [$];
    int          num_errors, total_checks, n_done, n_spw, n_opw, n_cw;

    bucs_branch_unit u_dut (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(i_ce), .i_code_byte(i_code_byte),
        .o_code_addr(o_code_addr), .o_code_rd(o_code_rd), .i_acc(i_acc), .i_data_pointer(i_data_pointer),
        .i_sp(i_sp), .i_operand_byte(i_operand_byte), .o_opcode(o_opcode),
        .o_operand_addr(o_operand_addr), .o_operand_we(o_operand_we),
        .o_operand_wdata(o_operand_wdata), .o_carry_we(o_carry_we), .o_carry(o_carry),
        .o_sp_we(o_sp_we), .o_sp(o_sp), .i_stack_byte(i_stack_byte),
        .o_stack_addr(o_stack_addr), .o_stack_we(o_stack_we), .o_stack_re(o_stack_re),
        .o_stack_wdata(o_stack_wdata), .o_int_done(o_int_done));

    bucs_code_mem u_mem (.i_clk(i_clk), .i_addr(o_code_addr), .i_rd(o_code_rd),
        .o_byte(i_code_byte));

    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    // internal stack ram and pulse counters
    always @(posedge i_clk) begin
        if (o_stack_we === 1'b1) stk[o_stack_addr] <= o_stack_wdata;
        if (o_stack_re === 1'b1) begin
            i_stack_byte <= stk[o_stack_addr];
            slast <= stk[o_stack_addr];
        end else begin
            i_stack_byte <= ~slast;
        end
        if (o_int_done === 1'b1) n_done++;
        if (o_sp_we === 1'b1) n_spw++;
        if (o_operand_we === 1'b1) n_opw++;
        if (o_carry_we === 1'b1) n_cw++;
    end

    task automatic err(input string m);
        num_errors++;
        $display("ERROR %0t %s", $time, m);
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic rw(input logic [15:0] pc, input logic [23:0] cd, input int cy = 2,
                      input logic [7:0] ac = 8'h00, ob = 8'h00, sp = 8'h00);
        rows.push_back('{pc, cd, cy, ac, ob, sp});
        u_mem.mem[pc] = cd[23:16];
        u_mem.mem[pc + 16'h0001] = cd[15:8];
        u_mem.mem[pc + 16'h0002] = cd[7:0];
    endtask

    task automatic wait_rd;
        int n;
        n = 0;
        @(posedge i_clk);
        while (o_code_rd !== 1'b1 && n < 40) begin
            @(posedge i_clk);
            n++;
        end
    endtask

    initial begin
        repeat (3000) @(posedge i_clk);
        err("watchdog");
        give_verdict();
    end

    initial begin
        int n;
        int nrd;
        i_reset_n = 1'b0;
        i_ce = 1'b1;
        i_acc = 8'h00;
        i_data_pointer = 16'h2000;
        i_sp = 8'h00;
        i_operand_byte = 8'h00;
        #1;
        rw(16'h0000, 24'h020900);
        rw(16'h0900, 24'h801000);
        rw(16'h0912, 24'h808000);
        rw(16'h0894, 24'h807f00);
        rw(16'h0915, 24'h000000, 1);
        rw(16'h0916, 24'he15500);
        rw(16'h0f55, 24'h730000, 2, 8'h34);
        rw(16'h2034, 24'h601000);
        rw(16'h2046, 24'h601000, 2, 8'h01);
        rw(16'h2048, 24'h70f000, 2, 8'h01);
        rw(16'h203a, 24'h701000);
        rw(16'h203c, 24'h123000, 2, 8'h00, 8'h00, 8'h30);
        rw(16'h3000, 24'h320000, 2, 8'h00, 8'h00, 8'h32);
        rw(16'h203f, 24'hd54005, 2, 8'h00, 8'h01);
        rw(16'h2042, 24'hd81000, 2, 8'h00, 8'h02);
        rw(16'h2054, 24'hb40508, 2, 8'h03);
        rw(16'h205f, 24'hb54008, 2, 8'h09, 8'h09);
        rw(16'h2062, 24'hb60704, 2, 8'h00, 8'h08);
        rw(16'h2069, 24'h110000, 2, 8'h00, 8'h00, 8'h50);
        rw(16'h2000, 24'h220000, 2, 8'h00, 8'h00, 8'h52);
        rw(16'h206b, 24'he00000);
        rw(16'h206c, 24'h000000, 1);
        rw(16'h206d, 24'h000000, 1);
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1'b1;
        wait_rd();
        total_checks++;
        if (o_code_addr !== 16'h0000) err("first fetch address");
        for (int i = 0; i < rows.size() - 1; i++) begin
            i_acc <= rows[i].ac;
            i_operand_byte <= rows[i].ob;
            i_sp <= rows[i].sp;
            nrd = (rows[i].cd[23:16] === 8'he0) ? 2 : 2 * rows[i].cy;
            n = 0;
            repeat (12 * rows[i].cy) begin
                @(posedge i_clk);
                if (o_code_rd === 1'b1) n++;
            end
            total_checks++;
            if (n != nrd) err("fetch count");
            total_checks++;
            if (o_code_rd !== 1'b1 || o_code_addr !== rows[i + 1].pc) err("next address");
        end
        total_checks++;
        if (n_done != 1 || n_spw != 4) err("call return pulses");
        total_checks++;
        if (n_opw != 2 || n_cw != 3) err("write back pulses");
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        total_checks++;
        if (o_code_rd !== 1'b0 || o_opcode !== 8'h00) err("reset state");
        i_reset_n <= 1'b1;
        wait_rd();
        total_checks++;
        if (o_code_addr !== 16'h0000) err("restart address");
        give_verdict();
    end
endmodule
